/* tws_pkg.sv */
// Shared constants and types for the two-wire memory target
package tws_pkg;
  // Clock and program-cycle timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned WR_TIME_MS   = 5;
  // Longest time, so rounded down
  localparam int unsigned PROG_CYCLES  = (WR_TIME_MS * CLK_HZ) / 1000;
  // Word and page geometry
  localparam logic [3:0]  WORD_BITS    = 4'h8;
  localparam int unsigned PAGE_BYTES   = 8;
  localparam int unsigned ADDR_BITS    = 8;
  // Positions of the pins in the synchroniser vector
  localparam int unsigned PIN_SCL      = 0;
  localparam int unsigned PIN_SDA      = 1;
  localparam int unsigned PIN_WP       = 2;
  localparam int unsigned PIN_STRAP    = 3;
  localparam int unsigned PIN_N        = 6;
  // Idle bus reads high on both lines, straps and protect low
  localparam logic [5:0]  PIN_RST      = 6'h03;
  localparam logic [7:0]  ADDR_RST     = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_ACK_DEV, ST_WA, ST_ACK_WA, ST_WD, ST_ACK_WD, ST_RD, ST_RACK, ST_PROG
  } tws_state_t;

  // One received data byte and the word address it belongs to
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tws_wr_t;
endpackage

/* tws_eeprom.sv */
// Two-wire serial memory target: bus engine, page buffer, program timer and array
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - Falling data while clock high is start
// R2 - Rising data while clock high is stop
// R3 - Data changes only while clock low
// R4 - Eight-bit words, acknowledge driven low ninth clock
// R5 - Standby at power-up and after stop
// R6 - Nine clocks, start, stop recover the bus
// R7 - Address word carries device-type code on top
// R8 - Acknowledge only when straps and type match
// R9 - Mismatch: no acknowledge, back to standby
// R10 - Lowest address bit: one reads, zero writes
// R11 - Byte write: word address then data byte
// R12 - Stop starts program cycle, within 5 ms
// R13 - Program cycle ignores bus, never acknowledges
// R14 - Buffer up to eight bytes per write
// R15 - Host sends at most seven extra bytes
// R16 - Every page data byte is acknowledged
// R17 - Only low three address bits increment
// R18 - Over eight bytes overwrite earlier ones
// R19 - Acknowledge polling answers only when idle
// R20 - Write-protect high blocks all array writes
// R21 - Sample on clock rise, drive after fall
// R22 - Word address seven or eight bits wide
// R23 - Address counter keeps last address plus one
// R24 - Mid-byte start or stop aborts transfer
// R25 - Protected writes acknowledged but never programmed
module tws_eeprom
  import tws_pkg::*;
#(
  parameter int unsigned ADDR_W      = tws_pkg::ADDR_BITS,
  parameter int unsigned PROG_CYC    = tws_pkg::PROG_CYCLES,
  parameter logic [3:0]  DEV_TYPE    = 4'h5  // Arbitrary device-type code
)
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [2:0] strap_select_pins,
  input  wire logic       wp_in,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            standby,
  output logic            prog_busy
);
  import tws_pkg::*;

  localparam int unsigned PCW = $clog2(PROG_CYC + 1);

  logic [PIN_N-1:0]  s1_q, s2_q, s3_q, f_q;
  logic              scl_p_q, sda_p_q;
  tws_state_t        state_q, state_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        shift_q, shift_d;
  logic [7:0]        addr_q, addr_d;
  logic              oe_q, oe_d, rd_ack_q, rd_ack_d, sda_o_q, standby_q, busy_q;
  logic [3:0]        wr_cnt_q, wr_cnt_d;
  logic [PCW-1:0]    prog_cnt_q, prog_cnt_d;
  logic              push, pg_clr;
  tws_wr_t           fifo_q [2];
  logic [1:0]        wptr_q, rptr_q;
  logic [7:0]        pg_data_q [PAGE_BYTES];
  logic [7:0]        pg_vld_q;
  logic [4:0]        pg_row_q;
  logic [7:0]        mem_q [2**ADDR_W];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  wire [PIN_N-1:0] agree = s2_q ~^ s3_q;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
      f_q  <= PIN_RST;
    end
    else
    begin
      s1_q <= {strap_select_pins, wp_in, sda_in, scl_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (f_q & ~agree) | (s3_q & agree);
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= f_q[PIN_SCL];
      sda_p_q <= f_q[PIN_SDA];
    end

  //////////////////////////////////////////////////////////////////////////////
  // Bus events; a data change with clock high is never a data bit
  wire       scl_f     = f_q[PIN_SCL];
  wire       sda_f     = f_q[PIN_SDA];
  wire       wp_f      = f_q[PIN_WP];
  wire [2:0] strap_f   = f_q[PIN_STRAP +: 3];
  wire       scl_rise  = scl_f & ~scl_p_q;                          // [R21]
  wire       scl_fall  = ~scl_f & scl_p_q;
  wire       start_ev  = scl_f & scl_p_q & ~sda_f & sda_p_q;          // [R1] [R3]
  wire       stop_ev   = scl_f & scl_p_q & sda_f & ~sda_p_q;          // [R2] [R3]
  wire       in_rx     = (state_q == ST_DEV) || (state_q == ST_WA) || (state_q == ST_WD);
  wire       rx_bit    = in_rx & scl_rise & (cnt_q < WORD_BITS);       // [R4] [R21]
  wire       rx_done   = scl_fall & (cnt_q == WORD_BITS);
  wire       dev_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == strap_f);  // [R7] [R8]
  wire [7:0] rdata     = mem_q[addr_q[ADDR_W-1:0]];
  wire [7:0] addr_pg   = {addr_q[7:3], addr_q[2:0] + 3'h1};           // [R17]
  wire       fifo_empty = (wptr_q == rptr_q);
  wire       fifo_in_rdy = ((wptr_q ^ rptr_q) != 2'h2);
  wire       pop       = !fifo_empty && !pg_clr;
  wire       commit    = (state_q == ST_PROG) && fifo_empty && (prog_cnt_q == PCW'(PROG_CYC - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Protocol engine; start and stop override any partial byte
  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    shift_d    = shift_q;
    oe_d       = oe_q;
    addr_d     = addr_q;
    rd_ack_d   = rd_ack_q;
    wr_cnt_d   = wr_cnt_q;
    prog_cnt_d = prog_cnt_q;
    push       = 1'b0;
    pg_clr     = 1'b0;
    if (state_q == ST_PROG)
    begin
      // Bus fully ignored until the cycle ends, so polling sees no ack  [R13] [R19]
      oe_d = 1'b0;
      if (commit)
      begin
        state_d    = ST_IDLE;                                        // [R5]
        prog_cnt_d = '0;
      end
      else if (fifo_empty)
        prog_cnt_d = prog_cnt_q + PCW'(1);                           // [R12]
    end
    else if (start_ev)
    begin
      state_d  = ST_DEV;                                             // [R1] [R6] [R24]
      cnt_d    = 4'h0;
      oe_d     = 1'b0;
      pg_clr   = 1'b1;
      wr_cnt_d = 4'h0;
    end
    else if (stop_ev)
    begin
      oe_d     = 1'b0;
      wr_cnt_d = 4'h0;
      // Only whole data bytes count; protected writes are dropped      [R20] [R24] [R25]
      if (wr_cnt_q != 4'h0 && !wp_f)
        state_d = ST_PROG;                                           // [R12]
      else
      begin
        state_d = ST_IDLE;                                           // [R2] [R5]
        pg_clr  = 1'b1;
      end
    end
    else
    begin
      if (rx_bit)
      begin
        shift_d = {shift_q[6:0], sda_f};
        cnt_d   = cnt_q + 4'h1;
      end
      unique case (state_q)
        ST_IDLE: ;
        ST_DEV:
          if (rx_done)
          begin
            cnt_d   = 4'h0;
            oe_d    = dev_match;                                     // [R4] [R8]
            state_d = dev_match ? ST_ACK_DEV : ST_IDLE;              // [R9]
          end
        ST_WA:
          if (rx_done)
          begin
            cnt_d   = 4'h0;
            addr_d  = shift_q;                                       // [R11] [R22]
            oe_d    = 1'b1;
            state_d = ST_ACK_WA;
          end
        ST_WD:
          if (rx_done)
          begin
            cnt_d = 4'h0;
            // A full buffer refuses the byte rather than losing it
            if (fifo_in_rdy)
            begin
              push     = 1'b1;                                       // [R14] [R18]
              addr_d   = addr_pg;                                    // [R17] [R23]
              wr_cnt_d = (wr_cnt_q == 4'hF) ? wr_cnt_q : wr_cnt_q + 4'h1;
              oe_d     = 1'b1;                                       // [R16]
              state_d  = ST_ACK_WD;
            end
            else
              state_d = ST_IDLE;
          end
        ST_ACK_DEV, ST_RACK:
        begin
          if (scl_rise && state_q == ST_RACK)
            rd_ack_d = ~sda_f;
          if (scl_fall)
          begin
            if ((state_q == ST_ACK_DEV && shift_q[0]) || (state_q == ST_RACK && rd_ack_q))
            begin
              state_d = ST_RD;                                       // [R10]
              shift_d = rdata;
              oe_d    = ~rdata[7];                                   // [R21]
              cnt_d   = 4'h1;
            end
            else
            begin
              oe_d    = 1'b0;
              state_d = (state_q == ST_ACK_DEV) ? ST_WA : ST_IDLE;   // [R10]
            end
          end
        end
        ST_ACK_WA, ST_ACK_WD:
          if (scl_fall)
          begin
            oe_d    = 1'b0;
            state_d = ST_WD;
          end
        ST_RD:
          if (scl_fall)
          begin
            if (cnt_q == WORD_BITS)
            begin
              oe_d     = 1'b0;
              state_d  = ST_RACK;
              cnt_d    = 4'h0;
              rd_ack_d = 1'b0;
              addr_d   = addr_q + 8'h01;                             // [R23]
            end
            else
            begin
              oe_d    = ~shift_q[6];
              shift_d = {shift_q[6:0], 1'b0};
              cnt_d   = cnt_q + 4'h1;
            end
          end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // Engine registers; counter address survives between operations
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      addr_q     <= ADDR_RST;
      oe_q       <= 1'b0;
      rd_ack_q   <= 1'b0;
      wr_cnt_q   <= 4'h0;
      prog_cnt_q <= '0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      shift_q    <= shift_d;
      addr_q     <= addr_d;
      oe_q       <= oe_d;
      rd_ack_q   <= rd_ack_d;
      wr_cnt_q   <= wr_cnt_d;
      prog_cnt_q <= prog_cnt_d;
    end

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between the bus engine and the page buffer
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wptr_q <= 2'h0;
      rptr_q <= 2'h0;
    end
    else
    begin
      wptr_q <= wptr_q + {1'b0, push};
      rptr_q <= rptr_q + {1'b0, pop};
    end

  always_ff @(posedge clk)
    if (push)
      fifo_q[wptr_q[0]] <= '{addr: addr_q, data: shift_q};

  // Page buffer collects one sequence; later bytes overwrite same slot  [R14] [R18]
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pg_vld_q <= 8'h00;
      pg_row_q <= 5'h00;
    end
    else if (pg_clr || commit)
      pg_vld_q <= 8'h00;
    else if (pop)
    begin
      pg_vld_q[fifo_q[rptr_q[0]].addr[2:0]] <= 1'b1;
      pg_row_q <= fifo_q[rptr_q[0]].addr[7:3];
    end

  always_ff @(posedge clk)
    if (pop)
      pg_data_q[fifo_q[rptr_q[0]].addr[2:0]] <= fifo_q[rptr_q[0]].data;

  // Array update at the end of the program time, whole page at once
  always_ff @(posedge clk)
    for (int i = 0; i < PAGE_BYTES; i++)
      if (commit && pg_vld_q[i])
        mem_q[ADDR_W'({pg_row_q, 3'(i)})] <= pg_data_q[i];            // [R12] [R20]

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs; the pin is only ever pulled low
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sda_o_q   <= 1'b0;
      standby_q <= 1'b1;
      busy_q    <= 1'b0;
    end
    else
    begin
      sda_o_q   <= 1'b0;
      standby_q <= (state_d == ST_IDLE);                             // [R5]
      busy_q    <= (state_d == ST_PROG);
    end

  assign sda_o     = sda_o_q;
  assign sda_oe    = oe_q;
  assign standby   = standby_q;
  assign prog_busy = busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_start_to_dev: assert property (start_ev && state_q != ST_PROG |=> state_q == ST_DEV) // [R1]
    else $error("start not taken");
  a_stop_standby: assert property (stop_ev && state_q != ST_PROG && wr_cnt_q == 4'h0 |=> standby_q) // [R2]
    else $error("read stop did not reach standby");
  a_ack_ninth: assert property ((state_q inside {ST_ACK_DEV, ST_ACK_WA, ST_ACK_WD}) |-> oe_q) // [R4]
    else $error("acknowledge not driven");
  a_mismatch_nack: assert property (state_q == ST_DEV && rx_done && !dev_match |=> state_q == ST_IDLE && !oe_q) // [R9]
    else $error("mismatched address acknowledged");
  a_busy_quiet: assert property (state_q == ST_PROG |=> !oe_q && state_q inside {ST_PROG, ST_IDLE}) // [R13]
    else $error("bus driven during program cycle");
  a_prog_bound: assert property (busy_q |-> prog_cnt_q < PCW'(PROG_CYC)) // [R12]
    else $error("program cycle too long");
  a_prog_end: assert property (commit |=> !busy_q && standby_q) // [R12]
    else $error("program cycle did not end");
  a_wp_block: assert property ($rose(busy_q) |-> !$past(wp_f) && $past(wr_cnt_q) != 4'h0) // [R20]
    else $error("program cycle started when blocked");
  a_page_wrap: assert property (push |=> addr_q[7:3] == $past(addr_q[7:3]) && addr_q[2:0] == $past(addr_q[2:0]) + 3'h1) // [R17]
    else $error("page address did not wrap");
  a_drive_fall: assert property ($changed(oe_q) |-> $past(scl_fall || start_ev || stop_ev || state_q == ST_PROG)) // [R21]
    else $error("data pin changed off a clock fall");

  c_write_commit: cover property (commit && pg_vld_q != 8'h00);
  c_poll_busy: cover property (start_ev && state_q == ST_PROG);
  c_read_more: cover property (state_q == ST_RACK && rd_ack_q && scl_fall);
  c_page_over: cover property (wr_cnt_q == 4'h9);
endmodule

`default_nettype wire

/* tws_host_model.sv */
// Host bus controller model that drives the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tws_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // Six clocks per phase, so the target's replies land inside the low phase
  localparam int PH = 6;

  // Idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Data set while clock is low, line sampled at end of high phase
  task automatic bit_slot(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_low <= !b;
    tick(PH - 2);
    scl <= 1'b1;
    tick(PH);
    r = sda;
  endtask

  // Data falls while clock high
  task automatic start();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b0;
    tick(PH - 2);
    scl <= 1'b1;
    tick(PH);
    sda_low <= 1'b1;
    tick(PH);
  endtask

  // Data rises while clock high; clock then stands still
  task automatic stop();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(PH - 2);
    scl <= 1'b1;
    tick(PH);
    sda_low <= 1'b0;
    tick(PH);
  endtask

  // Eight bits MSB first, then the ninth slot released for the answer
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask

  // Read a byte, then acknowledge to continue or release to end
  task automatic get(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_slot(1'b1, b[i]);
    bit_slot(!more, r);
  endtask

  // Bus recovery: start, nine clocks, start, stop
  task automatic recover();
    logic r;
    start();
    repeat (9) bit_slot(1'b1, r);
    start();
    stop();
  endtask
endmodule
`default_nettype wire

/* tb_tws_eeprom.sv */
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ps
`default_nettype none
module tb_tws_eeprom;
  import tws_pkg::*;
  localparam int unsigned PC    = 400;
  localparam logic [3:0]  TYPE  = 4'h5;  // Arbitrary device-type code
  localparam logic [2:0]  STRAP = 3'h5;
  localparam logic [7:0]  DW    = {TYPE, STRAP, 1'b0};
  logic       clk, rst_b, wp_in, sda_o, sda_oe, standby, prog_busy, scl, h_low;
  logic [2:0] straps;
  int         mismatches, samples_checked;
  // Open-drain wire with pull-up
  wire logic  sda = !(h_low || (sda_oe && !sda_o));

  tws_eeprom #(.PROG_CYC(PC), .DEV_TYPE(TYPE)) tws_eeprom_i (.clk(clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .strap_select_pins(straps), .wp_in(wp_in), .sda_o(sda_o), .sda_oe(sda_oe),
    .standby(standby), .prog_busy(prog_busy));
  tws_host_model tws_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(h_low));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    mismatches++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_bit(input logic a, input logic e, input string m);
    samples_checked++;
    if (a !== e) fail(m);
  endtask
  task automatic chk_byte(input logic [7:0] a, input logic [7:0] e, input string m);
    samples_checked++;
    if (a !== e) fail(m);
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the program cycle; a hang ends the run
  task automatic wait_prog(input logic exp);
    int n;
    n = 0;
    tws_host_model_i.tick(4);
    chk_bit(prog_busy, exp, "busy after stop");
    while (prog_busy === 1'b1 && n < PC + 20)
    begin
      @(posedge clk);
      n++;
    end
    chk_bit(n < PC + 20, 1'b1, "program too long");
    if (n >= PC + 20) complete_run();
    tws_host_model_i.tick(4);
    chk_bit(standby, 1'b1, "no standby");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input logic stp);
    logic k;
    tws_host_model_i.start();
    tws_host_model_i.put(DW, k);
    chk_bit(k, 1'b1, "device word ack");
    tws_host_model_i.put(a, k);
    chk_bit(k, 1'b1, "word address ack");
    foreach (d[i])
    begin
      tws_host_model_i.put(d[i], k);
      chk_bit(k, 1'b1, "data ack");
    end
    if (stp) tws_host_model_i.stop();
  endtask

  // Random read: dummy write sets the address, then read n bytes
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
    logic       k;
    logic [7:0] b;
    q = {};
    wr(a, q, 1'b0);
    tws_host_model_i.start();
    tws_host_model_i.put(DW | 8'h01, k);
    chk_bit(k, 1'b1, "read word ack");
    for (int i = 0; i < n; i++)
    begin
      tws_host_model_i.get(i < n - 1, b);
      q.push_back(b);
    end
    tws_host_model_i.stop();
    tws_host_model_i.tick(6);
    chk_bit(standby, 1'b1, "no standby after read");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk_bit(standby, 1'b1, "reset standby");
    chk_bit(prog_busy, 1'b0, "reset busy");
    chk_bit(sda_oe, 1'b0, "reset drive");
    chk_bit(sda_o, 1'b0, "data pin level");
  endtask

  // Byte write, polling during and after the program cycle
  task automatic s_byte();
    logic       k;
    logic [7:0] q[$];
    wr(8'h13, {8'h5A}, 1'b1);
    tws_host_model_i.tick(4);
    chk_bit(prog_busy, 1'b1, "no program");
    tws_host_model_i.start();
    tws_host_model_i.put(DW, k);
    chk_bit(k, 1'b0, "ack while busy");
    tws_host_model_i.stop();
    wait_prog(1'b1);
    tws_host_model_i.start();
    tws_host_model_i.put(DW, k);
    chk_bit(k, 1'b1, "poll not acked");
    tws_host_model_i.stop();
    wait_prog(1'b0);
    rd(8'h13, 1, q);
    chk_byte(q[0], 8'h5A, "byte write data");
  endtask

  // Ten bytes from mid-page: low bits wrap, last two overwrite the first two
  task automatic s_page();
    logic [7:0] d[$];
    logic [7:0] q[$];
    logic [7:0] e [8];
    for (int i = 0; i < 10; i++)
    begin
      d.push_back(8'hA0 + 8'(i));
      e[(6 + i) % 8] = 8'hA0 + 8'(i);
    end
    wr(8'h26, d, 1'b1);
    wait_prog(1'b1);
    rd(8'h20, 8, q);
    for (int j = 0; j < 8; j++)
      chk_byte(q[j], e[j], "page content");
  endtask

  // Wrong straps and wrong type code: no ack, back to standby
  task automatic s_mismatch();
    logic       k;
    logic [7:0] w [2];
    w[0] = {TYPE, ~STRAP, 1'b0};
    w[1] = {4'h6, STRAP, 1'b0};
    foreach (w[i])
    begin
      tws_host_model_i.start();
      tws_host_model_i.put(w[i], k);
      chk_bit(k, 1'b0, "mismatch acked");
      chk_bit(standby, 1'b1, "mismatch active");
      tws_host_model_i.stop();
    end
  endtask

  // Stop mid-byte programs nothing; recovery then a good write
  task automatic s_abort();
    logic       k;
    logic [7:0] q[$];
    wr(8'h14, q, 1'b0);
    repeat (4) tws_host_model_i.bit_slot(1'b0, k);
    tws_host_model_i.stop();
    wait_prog(1'b0);
    tws_host_model_i.start();
    tws_host_model_i.put(DW, k);
    repeat (3) tws_host_model_i.bit_slot(1'b0, k);
    tws_host_model_i.recover();
    wr(8'h14, {8'h77}, 1'b1);
    wait_prog(1'b1);
  endtask

  // Protected write is acked but leaves the array alone
  task automatic s_protect();
    logic       k;
    logic [7:0] b;
    logic [7:0] q[$];
    wp_in <= 1'b1;
    wr(8'h13, {8'hC3}, 1'b1);
    wait_prog(1'b0);
    wp_in <= 1'b0;
    rd(8'h13, 1, q);
    chk_byte(q[0], 8'h5A, "protected overwrite");
    tws_host_model_i.start();
    tws_host_model_i.put(DW | 8'h01, k);
    chk_bit(k, 1'b1, "current read ack");
    tws_host_model_i.get(1'b0, b);
    tws_host_model_i.stop();
    chk_byte(b, 8'h77, "current address read");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    wp_in = 1'b0;
    straps = STRAP;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    s_reset();
    s_byte();
    s_page();
    s_mismatch();
    s_abort();
    s_protect();
    complete_run();
  end

  // Hang guard well beyond the whole sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    fail("timeout");
    complete_run();
  end
endmodule
`default_nettype wire
